// [inc/sd_xfer_cfg.svh]
// Register map, field positions, FIFO depth and thresholds of the block transfer engine
`ifndef SD_XFER_CFG_SVH
`define SD_XFER_CFG_SVH
`define OFS_CTL      8'h00
`define OFS_CLK      8'h04
`define OFS_ST       8'h08
`define OFS_MASK     8'h10
`define OFS_BLEN     8'h1c
`define OFS_NBLK     8'h20
`define OFS_NBLC     8'h24
`define OFS_RX       8'h28
`define OFS_TX       8'h2c
`define OFS_CMD      8'h30
`define OFS_ARG      8'h34
`define OFS_SDCTL    8'h64
`define OFS_SDST     8'h68
`define OFS_SDIEN    8'h6c
`define OFS_SDIST    8'h70
`define OFS_FCTL     8'h74
`define ST_DONE      0
`define ST_TXRDY     9
`define ST_RXRDY     10
`define ST_TRN       12
`define CMD_DATA_CLEAR_OPTION     7
`define CMD_STOP     12
`define CMD_TRIG     16
`define FIFO_DEPTH   16
`define THR_LO_WORDS 5'd8
`define THR_HI_WORDS 5'd16
`define BLEN_RESET   12'h200
`endif

// [inc/sd_xfer_pkg.sv]
// Types of the block transfer engine
package sd_xfer_pkg;
  typedef enum logic [1:0] {X_IDLE, X_START, X_DATA, X_GAP} xfer_state_t;
  typedef struct packed {
    logic [1:0] width;
    logic       thr;
    logic       dir_tx;
  } fifo_ctl_t;
  typedef struct packed {
    logic       on;
    logic [7:0] rate;
  } card_clk_t;
endpackage : sd_xfer_pkg

// [rtl/sd_xfer.sv]
// Block transfer engine with FIFO, card clock, SDIO read-wait and interrupts
`timescale 1ns/10ps
`include "sd_xfer_cfg.svh"
module sd_xfer
  import sd_xfer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             card_clk,
  input  wire logic        data_line_0_in,
  output logic             data_line_0_out,
  output logic             data_line_0_oe,
  input  wire logic        data_line_1,
  output logic             data_line_2_out,
  output logic             data_line_2_oe,
  output logic             dma_tx_req,
  output logic             dma_rx_req,
  output logic             main_irq,
  output logic             sdio_irq
);
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        data_logic_reset_q;
  card_clk_t   cclk_q;
  fifo_ctl_t   fctl_q;
  logic [11:0] blen_q;
  logic [15:0] nblk_q, left_q, mask_q;
  logic [31:0] arg_q, cmd_q;
  logic        rw_req_q;
  logic [1:0]  sdien_q, sdist_q;
  logic [15:0] st_q;
  logic [31:0] mem_q [`FIFO_DEPTH];
  logic [4:0]  wp_q, rp_q;
  logic [7:0]  div_q;
  logic        clk_q;
  logic [1:0]  s1_q, s2_q;
  xfer_state_t xs_q;
  logic [31:0] sh_q;
  logic [15:0] bc_q;
  logic        d0_q, d0oe_q, d2oe_q, rwa_q, iper_q;
  logic        txreq_q, rxreq_q, mirq_q, sirq_q;

  // Bus decode
  wire        wr_go   = awvalid & wvalid & ~awready_q & ~bvalid_q;
  wire        wr_do   = awready_q;
  wire        rd_go   = arvalid & ~arready_q & ~rvalid_q;
  wire        rd_do   = arready_q;
  wire [31:0] wmask   = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire        w_ctl   = wr_do & (awaddr == `OFS_CTL);
  wire        w_clk   = wr_do & (awaddr == `OFS_CLK);
  wire        w_mask  = wr_do & (awaddr == `OFS_MASK);
  wire        w_blen  = wr_do & (awaddr == `OFS_BLEN);
  wire        w_nblk  = wr_do & (awaddr == `OFS_NBLK);
  wire        w_tx    = wr_do & (awaddr == `OFS_TX);
  wire        w_cmd   = wr_do & (awaddr == `OFS_CMD);
  wire        w_arg   = wr_do & (awaddr == `OFS_ARG);
  wire        w_sdctl = wr_do & (awaddr == `OFS_SDCTL);
  wire        w_sdien = wr_do & (awaddr == `OFS_SDIEN);
  wire        w_sdist = wr_do & (awaddr == `OFS_SDIST);
  wire        w_fctl  = wr_do & (awaddr == `OFS_FCTL);
  wire        r_st    = rd_do & (araddr == `OFS_ST);
  wire        r_rx    = rd_do & (araddr == `OFS_RX);
  wire [31:0] wd      = wdata & wmask;
  wire        trig    = w_cmd & wd[`CMD_TRIG];
  wire        data_clear_option    = w_cmd & wd[`CMD_DATA_CLEAR_OPTION];
  wire        stop    = w_cmd & wd[`CMD_STOP];
  wire        fifo_rst = w_fctl & wd[0];

  // FIFO
  wire [4:0]  cnt    = wp_q - rp_q;
  wire        f_emp  = (cnt == 5'd0);
  wire        f_full = (cnt == 5'(`FIFO_DEPTH));
  wire [4:0]  thr_w  = fctl_q.thr ? `THR_HI_WORDS : `THR_LO_WORDS;
  wire [4:0]  free   = 5'(`FIFO_DEPTH) - cnt;
  wire [31:0] head   = mem_q[rp_q[3:0]];

  // Card clock edges from the divider
  wire        tick    = cclk_q.on & (div_q == cclk_q.rate);
  wire        rise_en = tick & ~clk_q;
  wire        fall_en = tick & clk_q;
  wire        d0_s    = s2_q[0];
  wire        d1_s    = s2_q[1];

  // Engine decode
  wire [15:0] last_bit = {1'b0, blen_q, 3'b000} - 16'd1;
  wire        is_last  = (bc_q == last_bit);
  wire        tx_mode  = fctl_q.dir_tx;
  wire        bit_en   = tx_mode ? fall_en : rise_en;
  wire        in_data  = (xs_q == X_DATA) & bit_en;
  wire        tx_start = (xs_q == X_START) & tx_mode & fall_en & ~f_emp;
  wire        rx_start = (xs_q == X_START) & ~tx_mode & rise_en & ~d0_s;
  wire        blk_end  = in_data & is_last;
  wire        final_blk = blk_end & (nblk_q != 16'd0) & (left_q == 16'd1);
  wire        wrd_end  = in_data & (bc_q[4:0] == 5'd31);
  wire [31:0] rx_word  = {sh_q[30:0], d0_s};
  wire        rw_go    = (xs_q == X_GAP) & ~tx_mode & rw_req_q;

  // Direction gates every FIFO port
  wire        push   = ~f_full & (tx_mode ? w_tx : wrd_end);
  wire [31:0] push_d = tx_mode ? wd : rx_word;
  wire        pop    = ~f_emp & (tx_mode ? (tx_start | (wrd_end & ~is_last))
                                         : r_rx);

  // SDIO events
  wire        iper_d  = ~d1_s & cclk_q.on & (xs_q != X_DATA);
  wire        card_ev = iper_d & ~iper_q;
  wire        rw_ev   = rw_go & ~rwa_q;

  // Main status next value; set wins over read clear
  wire        done_ev = final_blk | (stop & (xs_q != X_IDLE));
  wire        rxrdy   = ~tx_mode & ((cnt >= thr_w) | ((xs_q == X_IDLE) & ~f_emp));
  wire        txrdy_s = data_logic_reset_q | data_clear_option | (tx_mode & (w_tx | (free >= thr_w)));
  wire [15:0] st_set  = 16'((done_ev ? 16'h1 : 16'h0) | (blk_end ? 16'h1000 : 16'h0));
  wire [15:0] st_keep = r_st ? 16'h0 : st_q;
  logic [15:0] st_d;
  always_comb begin
    st_d = (st_keep | st_set);
    st_d[`ST_RXRDY] = rxrdy;
    st_d[`ST_TXRDY] = txrdy_s | (st_q[`ST_TXRDY] & (free >= thr_w));
  end

  // Read mux
  logic [31:0] rmux;
  logic        rmap;
  always_comb begin
    rmap = 1'b1;
    case (araddr)
      `OFS_CTL:   rmux = {31'h0, data_logic_reset_q};
      `OFS_CLK:   rmux = {23'h0, cclk_q};
      `OFS_ST:    rmux = {16'h0, st_q};
      `OFS_MASK:  rmux = {16'h0, mask_q};
      `OFS_BLEN:  rmux = {20'h0, blen_q};
      `OFS_NBLK:  rmux = {16'h0, nblk_q};
      `OFS_NBLC:  rmux = {16'h0, left_q};
      `OFS_RX:    rmux = head;
      `OFS_CMD:   rmux = cmd_q;
      `OFS_ARG:   rmux = arg_q;
      `OFS_SDCTL: rmux = {31'h0, rw_req_q};
      `OFS_SDST:  rmux = {29'h0, rwa_q, iper_q, d1_s};
      `OFS_SDIEN: rmux = {30'h0, sdien_q};
      `OFS_SDIST: rmux = {30'h0, sdist_q};
      `OFS_FCTL:  rmux = {27'h0, fctl_q.width, fctl_q.thr, fctl_q.dir_tx, 1'b0};
      default: begin
        rmux = 32'h0;
        rmap = 1'b0;
      end
    endcase
  end
  wire wmap = (awaddr == `OFS_CTL) | (awaddr == `OFS_CLK) | (awaddr == `OFS_MASK)
            | (awaddr == `OFS_BLEN) | (awaddr == `OFS_NBLK) | (awaddr == `OFS_TX)
            | (awaddr == `OFS_CMD) | (awaddr == `OFS_ARG) | (awaddr == `OFS_SDCTL)
            | (awaddr == `OFS_SDIEN) | (awaddr == `OFS_SDIST) | (awaddr == `OFS_FCTL);

  // Bus handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'b00;
      rdata_q   <= 32'h0;
    end else begin
      awready_q <= wr_go;
      wready_q  <= wr_go;
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wmap ? 2'b00 : 2'b10;
      end else if (bready) bvalid_q <= 1'b0;
      arready_q <= rd_go;
      if (rd_do) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rmap ? 2'b00 : 2'b10;
        rdata_q  <= rmux;
      end else if (rready) rvalid_q <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_logic_reset_q <= 1'b0;
      cclk_q   <= '0;
      mask_q   <= 16'h0;
      blen_q   <= `BLEN_RESET;
      nblk_q   <= 16'h0;
      cmd_q    <= 32'h0;
      arg_q    <= 32'h0;
      rw_req_q <= 1'b0;
      sdien_q  <= 2'b00;
      fctl_q   <= '0;
    end else begin
      if (w_ctl)   data_logic_reset_q <= wd[0];
      if (w_clk)   cclk_q   <= wd[8:0];
      if (w_mask)  mask_q   <= wd[15:0];
      if (w_blen)  blen_q   <= wd[11:0];
      if (w_nblk)  nblk_q   <= wd[15:0];
      if (w_cmd)   cmd_q    <= wd & ~(32'h1 << `CMD_TRIG);
      if (w_arg)   arg_q    <= (arg_q & ~wmask) | wd;
      if (w_sdctl) rw_req_q <= wd[0];
      if (w_sdien) sdien_q  <= wd[1:0];
      if (w_fctl)  fctl_q   <= wd[4:1];
    end
  end

  // FIFO storage; data reset and FIFO reset both empty it
  always_ff @(posedge aclk) begin
    if (!aresetn || fifo_rst || data_logic_reset_q) begin
      wp_q <= 5'd0;
      rp_q <= 5'd0;
    end else begin
      if (push) wp_q <= wp_q + 5'd1;
      if (pop)  rp_q <= rp_q + 5'd1;
    end
  end
  always_ff @(posedge aclk) begin
    if (push) mem_q[wp_q[3:0]] <= push_d;
  end

  // Card clock divider and line synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 8'h0;
      clk_q <= 1'b0;
      s1_q  <= 2'b11;
      s2_q  <= 2'b11;
    end else begin
      s1_q <= {data_line_1, data_line_0_in};
      s2_q <= s1_q;
      div_q <= (tick | ~cclk_q.on) ? 8'h0 : div_q + 8'h1;
      clk_q <= cclk_q.on & (clk_q ^ tick);
    end
  end

  // Transfer sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || data_logic_reset_q) begin
      xs_q   <= X_IDLE;
      sh_q   <= 32'h0;
      bc_q   <= 16'h0;
      left_q <= 16'h0;
      d0_q   <= 1'b1;
      d0oe_q <= 1'b0;
    end else if (stop) begin
      xs_q   <= X_IDLE;
      d0oe_q <= 1'b0;
    end else begin
      case (xs_q)
        X_IDLE: if (trig) begin
          xs_q   <= X_START;
          left_q <= nblk_q;
          d0oe_q <= tx_mode;
          d0_q   <= 1'b1;
        end else if (bit_en) d0oe_q <= 1'b0; // Last bit stands a full period
        X_START: if (tx_start) begin
          d0_q <= 1'b0;
          sh_q <= head;
          bc_q <= 16'h0;
          xs_q <= X_DATA;
        end else if (rx_start) begin
          bc_q <= 16'h0;
          xs_q <= X_DATA;
        end
        X_DATA: if (in_data) begin
          bc_q <= bc_q + 16'd1;
          if (tx_mode) begin
            d0_q <= sh_q[31];
            sh_q <= (wrd_end & ~is_last) ? head : {sh_q[30:0], 1'b0};
          end else sh_q <= rx_word;
          if (blk_end) begin
            left_q <= left_q - 16'd1;
            xs_q   <= final_blk ? X_IDLE : X_GAP;
          end
        end
        X_GAP: if (bit_en & ~rw_go) begin
          xs_q <= X_START;
          d0_q <= 1'b1;
        end
        default: xs_q <= X_IDLE;
      endcase
    end
  end

  // Status, SDIO flags and interrupt outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= 16'h0200;
      sdist_q <= 2'b00;
      rwa_q   <= 1'b0;
      iper_q  <= 1'b0;
      d2oe_q  <= 1'b0;
      txreq_q <= 1'b0;
      rxreq_q <= 1'b0;
      mirq_q  <= 1'b0;
      sirq_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      rwa_q   <= rw_go;
      d2oe_q  <= rw_go;
      iper_q  <= iper_d;
      // Write-one clears; a new event in the same cycle wins
      sdist_q <= (sdist_q & ~(w_sdist ? wd[1:0] : 2'b00)) | {rw_ev, card_ev};
      txreq_q <= (xs_q != X_IDLE) & tx_mode & st_d[`ST_TXRDY];
      rxreq_q <= ~tx_mode & st_d[`ST_RXRDY];
      mirq_q  <= |(st_d & mask_q);
      sirq_q  <= |(sdist_q & sdien_q);
    end
  end

  assign awready         = awready_q;
  assign wready          = wready_q;
  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;
  assign arready         = arready_q;
  assign rvalid          = rvalid_q;
  assign rresp           = rresp_q;
  assign rdata           = rdata_q;
  assign card_clk        = clk_q;
  assign data_line_0_out = d0_q;
  assign data_line_0_oe  = d0oe_q;
  assign data_line_2_out = 1'b0;
  assign data_line_2_oe  = d2oe_q;
  assign dma_tx_req      = txreq_q;
  assign dma_rx_req      = rxreq_q;
  assign main_irq        = mirq_q;
  assign sdio_irq        = sirq_q;
endmodule : sd_xfer

// [verif/sd_card_model.sv]
// Card-side model: takes written blocks, sends read blocks, signals interrupts
`timescale 1ns/10ps
module sd_card_model (
  input  wire logic        card_clk,
  input  wire logic        line0,
  input  wire logic        host_oe,
  input  wire logic        send_tgl,
  input  wire logic [31:0] send_word,
  input  wire logic        irq_req,
  output logic             drive0,
  output logic             data_line_1,
  output logic [31:0]      got_word,
  output int               frames
);
  localparam int BITS = 32; // Same block length as the host
  logic        in_frame;
  logic        seen;
  logic [32:0] tx_sh;
  int          cnt;
  int          left;
  // Pull-up on line 1: a quiet card reads high
  assign data_line_1 = !irq_req;
  initial begin
    in_frame = 1'b0;
    seen = 1'b0;
    tx_sh = 33'h0;
    cnt = 0;
    left = 0;
    frames = 0;
    got_word = 32'h0;
    drive0 = 1'b1;
  end
  always @(posedge card_clk) begin
    if (host_oe && !in_frame && !line0) begin
      in_frame = 1'b1;
      cnt = 0;
    end else if (host_oe && in_frame) begin
      got_word = {got_word[30:0], line0};
      cnt++;
      if (cnt == BITS) begin
        in_frame = 1'b0;
        frames++;
      end
    end
  end
  // Start bit, then data MSB first; idle line rests at the pull-up
  always @(negedge card_clk) begin
    if (left == 0 && send_tgl != seen) begin
      seen = send_tgl;
      tx_sh = {1'b0, send_word};
      left = BITS + 1;
    end
    if (left > 0) begin
      drive0 <= tx_sh[32];
      tx_sh = tx_sh << 1;
      left--;
    end else begin
      drive0 <= 1'b1;
    end
  end
endmodule : sd_card_model

// [verif/sd_xfer_asserts.sv]
// Port checker for the block transfer engine
`timescale 1ns/10ps
`include "sd_xfer_cfg.svh"
module sd_xfer_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  awaddr,
  input wire logic [31:0] wdata,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        card_clk,
  input wire logic        data_line_0_oe,
  input wire logic        data_line_2_out,
  input wire logic        data_line_2_oe,
  input wire logic        dma_tx_req,
  input wire logic        sdio_irq
);
  // Shadow of settings seen on the bus
  logic [1:0] en_q;
  logic       clk_on_q;
  logic       tx_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q     <= 2'h0;
      clk_on_q <= 1'b0;
      tx_q     <= 1'b0;
    end else if (awready) begin
      if (awaddr == `OFS_SDIEN) en_q <= wdata[1:0];
      if (awaddr == `OFS_CLK) clk_on_q <= wdata[8];
      if (awaddr == `OFS_FCTL) tx_q <= wdata[1];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rw_low; data_line_2_oe |-> !data_line_2_out; endproperty
  a_rw_low: assert property (p_rw_low) else $error("line 2 not low");
  property p_rw_rd; data_line_2_oe |-> !data_line_0_oe; endproperty
  a_rw_rd: assert property (p_rw_rd) else $error("read-wait in write");
  property p_rw_irq; $rose(data_line_2_oe) && en_q[1] |-> ##[0:6] sdio_irq; endproperty
  a_rw_irq: assert property (p_rw_irq) else $error("no read-wait irq");
  property p_irq_off; (en_q == 2'h0) [*3] |-> !sdio_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked irq seen");
  property p_clk_off; !clk_on_q [*3] |-> !card_clk; endproperty
  a_clk_off: assert property (p_clk_off) else $error("card clock runs");
  property p_oe_dir; !tx_q [*2] |-> !data_line_0_oe; endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("drive in receive");
  property p_txreq; !tx_q [*2] |-> !dma_tx_req; endproperty
  a_txreq: assert property (p_txreq) else $error("tx request in receive");
  property p_bhold; bvalid && !bready |=> bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  c_rw: cover property ($rose(data_line_2_oe));
  c_irq: cover property ($rose(sdio_irq));
  c_wr: cover property ($rose(data_line_0_oe));
endmodule : sd_xfer_asserts
bind sd_xfer sd_xfer_asserts sd_xfer_asserts_inst (.*);

// [verif/sd_xfer_test.sv]
// Testbench for the block transfer engine
`timescale 1ns/10ps
`include "sd_xfer_cfg.svh"
module sd_xfer_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, send_word, got_word;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  logic        awready, wready, bvalid, arready, rvalid, card_clk, data_line_0_out;
  logic        data_line_0_oe, data_line_1, data_line_2_out, data_line_2_oe, dma_tx_req;
  logic        dma_rx_req, main_irq, sdio_irq, drive0, irq_req, send_tgl;
  int          frames;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  wire         data_line_0_in = data_line_0_oe ? data_line_0_out : drive0;
  sd_xfer sd_xfer_inst (.*);
  sd_card_model sd_card_model_inst (.card_clk(card_clk), .line0(data_line_0_in),
    .host_oe(data_line_0_oe), .send_tgl(send_tgl), .send_word(send_word),
    .irq_req(irq_req), .drive0(drive0), .data_line_1(data_line_1),
    .got_word(got_word), .frames(frames));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Hang guard, far above the 1300 or so cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 60);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 60);
    rd = rdata;
    rr = rresp;
  endtask : rd_reg
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a);
    chk(rd & m, e);
  endtask : rchk
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd_reg(a);
      n++;
    end while ((rd & m) == 32'h0 && n < 400);
    chk(rd & m, m);
  endtask : poll
  task automatic t_reset;
    rchk(`OFS_ST, 32'hffff_ffff, 32'h200);
    rchk(`OFS_BLEN, 32'hfff, 32'h200);
    rchk(8'h0c, 32'hffff_ffff, 32'h0);
    chk({30'h0, rr}, 32'h2);
  endtask : t_reset
  // Two one-word blocks; the count alone ends the run
  task automatic t_write;
    wr(`OFS_CLK, 32'h103);
    wr(`OFS_BLEN, 32'h4);
    wr(`OFS_ARG, 32'h0007_0200);
    rchk(`OFS_ARG, 32'hffff_ffff, 32'h0007_0200);
    wr(`OFS_NBLK, 32'h2);
    wr(`OFS_FCTL, 32'h7);
    rchk(`OFS_FCTL, 32'h7, 32'h6);
    rchk(`OFS_ST, 32'h200, 32'h200);
    wr(`OFS_TX, 32'ha5c3_0f1e);
    // Fifteen free words are short of a 64-byte chunk
    rchk(`OFS_ST, 32'h200, 32'h0);
    wr(`OFS_TX, 32'h1234_5678);
    wr(`OFS_CMD, 32'h0001_0000);
    poll(`OFS_ST, 32'h1);
    // Card takes the last bit half a card period after done
    repeat (8) @(posedge aclk);
    chk(32'(frames), 32'h2);
    chk(got_word, 32'h1234_5678);
    rchk(`OFS_ST, 32'h1201, 32'h200);
  endtask : t_write
  // Read with a read-wait pause between the two blocks
  task automatic t_read;
    wr(`OFS_FCTL, 32'h1);
    wr(`OFS_SDIEN, 32'h2);
    wr(`OFS_SDCTL, 32'h1);
    wr(`OFS_MASK, 32'h400);
    wr(`OFS_CMD, 32'h0001_0000);
    send_word <= 32'hc3a5_5a3c;
    send_tgl <= ~send_tgl;
    poll(`OFS_SDIST, 32'h2);
    chk({31'h0, data_line_2_oe}, 32'h1);
    chk({31'h0, sdio_irq}, 32'h1);
    rchk(`OFS_SDST, 32'h4, 32'h4);
    wr(`OFS_SDCTL, 32'h0);
    // Let the engine leave read-wait before the card starts
    repeat (8) @(posedge aclk);
    wr(`OFS_SDIST, 32'h2);
    send_word <= 32'h0ff0_9669;
    send_tgl <= ~send_tgl;
    poll(`OFS_ST, 32'h1);
    chk({31'h0, dma_rx_req}, 32'h1);
    chk({31'h0, main_irq}, 32'h1);
    rchk(`OFS_RX, 32'hffff_ffff, 32'hc3a5_5a3c);
    rchk(`OFS_RX, 32'hffff_ffff, 32'h0ff0_9669);
    repeat (2) @(posedge aclk);
    chk({31'h0, dma_rx_req}, 32'h0);
    chk({31'h0, main_irq}, 32'h0);
  endtask : t_read
  // Open-ended read ended by a stop command
  task automatic t_stop;
    wr(`OFS_NBLK, 32'h0);
    wr(`OFS_FCTL, 32'h1);
    wr(`OFS_CMD, 32'h0001_0000);
    wr(`OFS_CMD, 32'h0000_1000);
    poll(`OFS_ST, 32'h1);
  endtask : t_stop
  task automatic t_sdio;
    wr(`OFS_SDIEN, 32'h1);
    irq_req <= 1'b1;
    poll(`OFS_SDIST, 32'h1);
    chk({31'h0, sdio_irq}, 32'h1);
    rchk(`OFS_SDST, 32'h3, 32'h2);
    irq_req <= 1'b0;
    repeat (6) @(posedge aclk);
    wr(`OFS_SDIST, 32'h1);
    rchk(`OFS_SDIST, 32'h3, 32'h0);
    wr(`OFS_SDIEN, 32'h0);
    irq_req <= 1'b1;
    poll(`OFS_SDIST, 32'h1);
    chk({31'h0, sdio_irq}, 32'h0);
    irq_req <= 1'b0;
  endtask : t_sdio
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_req, send_tgl} = 8'h0;
    {awaddr, araddr, wdata, send_word} = 80'h0;
    wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_sdio();
    t_stop();
    close_out();
  end
endmodule : sd_xfer_test
